// ===== verilog/ghia_consts.vh
/*
  Constants for the gauge host command port: target address, command
  locations, authentication block layout, hash constants, timing.
  Assumes a 100 MHz core clock.
*/
`ifndef GHIA_CONSTS_VH
`define GHIA_CONSTS_VH

// ****************************************
// bus addressing
// ****************************************
`define DEV_ADDR 7'h55
`define CMD_MAX 8'h7f

// ****************************************
// command locations
// ****************************************
`define BUF_BASE 8'h40
`define BUF_LAST 8'h5f
`define CMD_SUBCLASS 8'h3e
`define CMD_BLOCK 8'h3f
`define CMD_CHAL_SUM 8'h54
`define CMD_BLOCK_SUM 8'h60
`define CMD_ACCESS 8'h61

// ****************************************
// authentication values
// ****************************************
`define ACC_KEY_MODE 8'h00
`define ACC_CHAL_MODE 8'h01
`define KEY_SUBCLASS 8'h70
`define KEY_BLOCK 8'h00
`define SUM_GOOD 8'hff
`define CHAL_BYTES 20
`define KEY_FIRST 12
`define KEY_END 28
`define KEY_RESET 128'h0123456789abcdeffedcba987654321
`define HMAC_IPAD 8'h36
`define HMAC_OPAD 8'h5c
`define HMAC_LEN 64'h00000000000002a0
`define SHA_IV 160'h67452301efcdab8998badcfe10325476c3d2e1f0
`define SHA_K0 32'h5a827999
`define SHA_K1 32'h6ed9eba1
`define SHA_K2 32'h8f1bbcdc
`define SHA_K3 32'hca62c1d6
`define SHA_ROUNDS 7'd80

// ****************************************
// timing
// ****************************************
`define CLK_FREQ_MHZ 100
`define BUS_STUCK_US 2000
`define BUS_STUCK_CYC (`BUS_STUCK_US * `CLK_FREQ_MHZ)

`endif

// ===== verilog/ghia_sha1_core.v
/*
  Iterative SHA-1 compression, one round per enabled clock.
  Assumes the caller holds block stable while busy is high.
*/
`timescale 1ns/1ps
`include "ghia_consts.vh"
module ghia_sha1_core (
    input wire clock,
    input wire rst_n,
    input wire clkEn,
    input wire start,
    input wire first,
    input wire [511:0] block,
    output reg busy,
    output reg done,
    output reg [159:0] hash
);

reg [31:0] aQ, bQ, cQ, dQ, eQ;
reg [511:0] wQ;
reg [6:0] roundQ;
reg [31:0] f;
reg [31:0] k;
wire [31:0] temp;
wire [31:0] wNew;
wire [31:0] w13 = wQ[95:64];
wire [31:0] w8 = wQ[255:224];
wire [31:0] w2 = wQ[447:416];
wire [31:0] w0 = wQ[511:480];
wire [159:0] base = first ? `SHA_IV : hash;

// ****************************************
// round function
// ****************************************
always @*
begin
    if (roundQ < 7'd20)
    begin
        f = (bQ & cQ) | (~bQ & dQ);
        k = `SHA_K0;
    end
    else if (roundQ < 7'd40)
    begin
        f = bQ ^ cQ ^ dQ;
        k = `SHA_K1;
    end
    else if (roundQ < 7'd60)
    begin
        f = (bQ & cQ) | (bQ & dQ) | (cQ & dQ);
        k = `SHA_K2;
    end
    else
    begin
        f = bQ ^ cQ ^ dQ;
        k = `SHA_K3;
    end
end

assign temp = {aQ[26:0], aQ[31:27]} + f + eQ + k + w0;
assign wNew = {w13[30:0] ^ w8[30:0] ^ w2[30:0] ^ w0[30:0], w13[31] ^ w8[31] ^ w2[31] ^ w0[31]};

// ****************************************
// state update
// ****************************************
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        aQ <= 32'h0;
        bQ <= 32'h0;
        cQ <= 32'h0;
        dQ <= 32'h0;
        eQ <= 32'h0;
        wQ <= 512'h0;
        roundQ <= 7'h0;
        busy <= 1'b0;
        done <= 1'b0;
        hash <= 160'h0;
    end
    else if (clkEn)
    begin
        done <= 1'b0;
        if (start && !busy)
        begin
            {aQ, bQ, cQ, dQ, eQ} <= base;
            hash <= base;
            wQ <= block;
            roundQ <= 7'h0;
            busy <= 1'b1;
        end
        else if (busy)
        begin
            eQ <= dQ;
            dQ <= cQ;
            cQ <= {bQ[1:0], bQ[31:2]};
            bQ <= aQ;
            aQ <= temp;
            wQ <= {wQ[479:0], wNew};
            roundQ <= roundQ + 7'd1;
            if (roundQ == `SHA_ROUNDS - 7'd1)
            begin
                hash <= {hash[159:128] + temp, hash[127:96] + aQ, hash[95:64] + {bQ[1:0], bQ[31:2]},
                         hash[63:32] + cQ, hash[31:0] + dQ};
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end
end

endmodule // ghia_sha1_core

// ===== verilog/ghia_host_port.v
/*
  Gauge host command port: byte-wide two-wire target with a command
  pointer, a 32-byte authentication buffer and keyed digest sequencing.
  Assumes pins are already synchronous to clock; the security state and
  the external-authentication strap come from the gauge core.
*/
// How it works
// - answer only target address 1010101, bytes 0xAA write, 0xAB read.
// - support standard read, incremental read, one-byte write and quick read.
// - a read with no command byte returns the byte at the pointer.
// - pointer advances on every acknowledged data byte, either side acking.
// - each single-byte write lands at the location named by its own command byte.
// - data written to a read-only location is not acknowledged.
// - a command byte above 0x7F is not acknowledged.
// - after the first write data byte, further data bytes are not acknowledged.
// - lines low for the stuck timeout make the port release the data line.
// - a line still held low after release puts the engine to sleep.
// - with external authentication, only relay challenge and digest over the link.
// - each 160-bit challenge yields a 160-bit keyed digest from the stored key.
// - new keys are accepted only in the open security state.
// - key commits only on a good checksum over the whole 0x40-0x5F block.
// - on a good challenge checksum, the digest overwrites the challenge buffer.
`timescale 1ns/1ps
`include "ghia_consts.vh"
module ghia_host_port #(
    parameter STUCK_CYCLES = `BUS_STUCK_CYC
) (
    input wire clock,
    input wire rst_n,
    input wire clkEn,
    input wire sclIn,
    output wire sclOut,
    output wire sclOen_n,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOen_n,
    input wire openState,
    input wire extAuthMode,
    output wire [159:0] swlChallenge,
    output reg swlReq,
    input wire [159:0] swlDigest,
    input wire swlDone,
    output reg authBusy,
    output reg engineSleep
);

localparam ST_IDLE = 5'b00001;
localparam ST_RX = 5'b00010;
localparam ST_ACK = 5'b00100;
localparam ST_TX = 5'b01000;
localparam ST_MACK = 5'b10000;
localparam K_ADDR = 2'd0;
localparam K_CMD = 2'd1;
localparam K_DATA = 2'd2;

reg [4:0] stateQ;
reg [1:0] kindQ;
reg [2:0] cntQ;
reg [7:0] shQ;
reg [7:0] ptrQ;
reg sclQ, sdaQ, byteDoneQ, ackOkQ, isReadQ, wroteQ, sdaDrvQ, releasedQ;
reg [31:0] stuckQ;
reg keyModeQ, chalModeQ;
reg [7:0] subclassQ, blockQ;
reg [127:0] keyQ;
reg [159:0] chalQ, innerQ;
reg [1:0] stepQ;
reg shaStartQ;
reg [7:0] bufMem [0:31];
reg [7:0] sumAll, sumChal;
reg [159:0] chalVec;
reg [127:0] keyVec;
reg [511:0] shaBlock;
integer i, j;
wire shaBusy, shaDone;
wire [159:0] shaHash;
wire [7:0] rxByte = {shQ[6:0], sdaIn};
wire sclRise = sclIn & ~sclQ;
wire sclFall = ~sclIn & sclQ;
wire startCond = sclIn & sclQ & sdaQ & ~sdaIn;
wire stopCond = sclIn & sclQ & ~sdaQ & sdaIn;
wire busLow = ~sclIn | ~sdaIn;
wire [511:0] keyPad = {keyQ, 384'h0};
wire dataOk = ~wroteQ & isWritable(ptrQ);
wire [7:0] ptrByte = readByte(ptrQ);

assign sclOut = 1'b0;
assign sclOen_n = 1'b1;
assign sdaOut = 1'b0;
assign sdaOen_n = ~(sdaDrvQ & ~releasedQ);
assign swlChallenge = chalQ;

// ****************************************
// decoding
// ****************************************
function isWritable;
    input [7:0] a;
    begin
        isWritable = (a >= `BUF_BASE && a <= `BUF_LAST) || a == `CMD_SUBCLASS || a == `CMD_BLOCK ||
                     a == `CMD_CHAL_SUM || a == `CMD_BLOCK_SUM || a == `CMD_ACCESS;
    end
endfunction

function [7:0] readByte;
    input [7:0] a;
    begin
        if (a >= `BUF_BASE && a <= `BUF_LAST)
            readByte = bufMem[a[4:0]];
        else if (a == `CMD_SUBCLASS)
            readByte = subclassQ;
        else if (a == `CMD_BLOCK)
            readByte = blockQ;
        else
            readByte = 8'h00;
    end
endfunction

// ****************************************
// checksums and block views
// ****************************************
always @*
begin
    sumAll = 8'h00;
    sumChal = 8'h00;
    chalVec = 160'h0;
    keyVec = 128'h0;
    for (i = 0; i < 32; i = i + 1)
    begin
        sumAll = sumAll + bufMem[i];
        if (i < `CHAL_BYTES)
        begin
            sumChal = sumChal + bufMem[i];
            chalVec = {chalVec[151:0], bufMem[i]};
        end
        if (i >= `KEY_FIRST && i < `KEY_END)
            keyVec = {keyVec[119:0], bufMem[i]};
    end
end

// ****************************************
// keyed hash block selection
// ****************************************
always @*
begin
    case (stepQ)
        2'd0: shaBlock = keyPad ^ {64{`HMAC_IPAD}};
        2'd1: shaBlock = {chalQ, 8'h80, 280'h0, `HMAC_LEN};
        2'd2: shaBlock = keyPad ^ {64{`HMAC_OPAD}};
        default: shaBlock = {innerQ, 8'h80, 280'h0, `HMAC_LEN};
    endcase
end

ghia_sha1_core uSha (
    .clock(clock),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .start(shaStartQ),
    .first(~stepQ[0]),
    .block(shaBlock),
    .busy(shaBusy),
    .done(shaDone),
    .hash(shaHash)
);

// ****************************************
// bus engine, registers, authentication
// ****************************************
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        stateQ <= ST_IDLE;
        kindQ <= K_ADDR;
        cntQ <= 3'h0;
        shQ <= 8'h00;
        ptrQ <= 8'h00;
        sclQ <= 1'b1;
        sdaQ <= 1'b1;
        byteDoneQ <= 1'b0;
        ackOkQ <= 1'b0;
        isReadQ <= 1'b0;
        wroteQ <= 1'b0;
        sdaDrvQ <= 1'b0;
        releasedQ <= 1'b0;
        stuckQ <= 32'h0;
        engineSleep <= 1'b0;
        keyModeQ <= 1'b0;
        chalModeQ <= 1'b0;
        subclassQ <= 8'h00;
        blockQ <= 8'h00;
        keyQ <= `KEY_RESET;
        chalQ <= 160'h0;
        innerQ <= 160'h0;
        stepQ <= 2'd0;
        shaStartQ <= 1'b0;
        swlReq <= 1'b0;
        authBusy <= 1'b0;
        for (j = 0; j < 32; j = j + 1)
            bufMem[j] <= 8'h00;
    end
    else if (clkEn)
    begin
        sclQ <= sclIn;
        sdaQ <= sdaIn;
        shaStartQ <= 1'b0;
        swlReq <= 1'b0;
        if (!busLow)
        begin
            stuckQ <= 32'h0;
            releasedQ <= 1'b0;
            engineSleep <= 1'b0;
        end
        else if (stuckQ == STUCK_CYCLES - 1)
        begin
            releasedQ <= 1'b1;
            engineSleep <= releasedQ;
        end
        else
            stuckQ <= stuckQ + 32'h1;
        if (releasedQ || stopCond)
        begin
            stateQ <= ST_IDLE;
            sdaDrvQ <= 1'b0;
        end
        else if (startCond)
        begin
            stateQ <= ST_RX;
            kindQ <= K_ADDR;
            cntQ <= 3'h0;
            wroteQ <= 1'b0;
            byteDoneQ <= 1'b0;
            sdaDrvQ <= 1'b0;
        end
        else
        begin
            case (stateQ)
                ST_RX:
                begin
                    if (sclRise)
                    begin
                        shQ <= rxByte;
                        cntQ <= cntQ + 3'd1;
                        if (cntQ == 3'd7)
                        begin
                            byteDoneQ <= 1'b1;
                            if (kindQ == K_ADDR)
                            begin
                                ackOkQ <= (rxByte[7:1] == `DEV_ADDR);
                                isReadQ <= rxByte[0];
                            end
                            else if (kindQ == K_CMD)
                            begin
                                ackOkQ <= (rxByte <= `CMD_MAX);
                                if (rxByte <= `CMD_MAX)
                                    ptrQ <= rxByte;
                            end
                            else
                            begin
                                ackOkQ <= dataOk;
                                wroteQ <= 1'b1;
                                if (dataOk)
                                begin
                                    ptrQ <= ptrQ + 8'd1;
                                    if (ptrQ >= `BUF_BASE && ptrQ <= `BUF_LAST && !authBusy)
                                        bufMem[ptrQ[4:0]] <= rxByte;
                                    if (ptrQ == `CMD_SUBCLASS)
                                        subclassQ <= rxByte;
                                    if (ptrQ == `CMD_BLOCK)
                                    begin
                                        blockQ <= rxByte;
                                        if (!openState && rxByte == `KEY_BLOCK)
                                            chalModeQ <= 1'b1;
                                    end
                                    if (ptrQ == `CMD_ACCESS && openState)
                                    begin
                                        keyModeQ <= (rxByte == `ACC_KEY_MODE);
                                        chalModeQ <= (rxByte == `ACC_CHAL_MODE);
                                    end
                                    if (ptrQ == `CMD_BLOCK_SUM && openState && keyModeQ &&
                                        subclassQ == `KEY_SUBCLASS && blockQ == `KEY_BLOCK &&
                                        sumAll + rxByte == `SUM_GOOD)
                                        keyQ <= keyVec;
                                    if (ptrQ == `CMD_CHAL_SUM && chalModeQ && !authBusy &&
                                        sumChal + rxByte == `SUM_GOOD)
                                    begin
                                        chalQ <= chalVec;
                                        authBusy <= 1'b1;
                                        stepQ <= 2'd0;
                                        swlReq <= extAuthMode;
                                        shaStartQ <= ~extAuthMode;
                                    end
                                end
                            end
                        end
                    end
                    else if (sclFall && byteDoneQ)
                    begin
                        byteDoneQ <= 1'b0;
                        stateQ <= ST_ACK;
                        sdaDrvQ <= ackOkQ;
                    end
                end
                ST_ACK:
                begin
                    if (sclFall)
                    begin
                        cntQ <= 3'h0;
                        if (!ackOkQ)
                        begin
                            stateQ <= ST_IDLE;
                            sdaDrvQ <= 1'b0;
                        end
                        else if (kindQ == K_ADDR && isReadQ)
                        begin
                            stateQ <= ST_TX;
                            shQ <= ptrByte;
                            sdaDrvQ <= ~ptrByte[7];
                        end
                        else
                        begin
                            stateQ <= ST_RX;
                            kindQ <= (kindQ == K_ADDR) ? K_CMD : K_DATA;
                            sdaDrvQ <= 1'b0;
                        end
                    end
                end
                ST_TX:
                begin
                    if (sclFall)
                    begin
                        cntQ <= cntQ + 3'd1;
                        shQ <= {shQ[6:0], 1'b0};
                        sdaDrvQ <= (cntQ == 3'd7) ? 1'b0 : ~shQ[6];
                        if (cntQ == 3'd7)
                            stateQ <= ST_MACK;
                    end
                end
                ST_MACK:
                begin
                    if (sclRise)
                    begin
                        ackOkQ <= ~sdaIn;
                        if (!sdaIn)
                            ptrQ <= ptrQ + 8'd1;
                    end
                    else if (sclFall)
                    begin
                        cntQ <= 3'h0;
                        stateQ <= ackOkQ ? ST_TX : ST_IDLE;
                        shQ <= ptrByte;
                        sdaDrvQ <= ackOkQ & ~ptrByte[7];
                    end
                end
                default:
                    sdaDrvQ <= 1'b0;
            endcase
        end
        if (shaDone)
        begin
            stepQ <= stepQ + 2'd1;
            shaStartQ <= (stepQ != 2'd3);
            if (stepQ == 2'd1)
                innerQ <= shaHash;
        end
        if ((shaDone && stepQ == 2'd3) || (swlDone && extAuthMode && authBusy))
        begin
            authBusy <= 1'b0;
            for (j = 0; j < `CHAL_BYTES; j = j + 1)
                bufMem[j] <= extAuthMode ? swlDigest[159 - 8 * j -: 8] : shaHash[159 - 8 * j -: 8];
        end
    end
end

endmodule // ghia_host_port

// ===== tb/ghia_host_port_chk.sv
/*
  Checker for the gauge host command port: pin drive, stuck-bus release,
  digest timing and the link handshake.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module ghia_host_port_chk #(
    parameter STUCK_CYCLES = 400
) (
    input wire clock,
    input wire rst_n,
    input wire sclIn,
    input wire sclOut,
    input wire sclOen_n,
    input wire sdaIn,
    input wire sdaOut,
    input wire sdaOen_n,
    input wire extAuthMode,
    input wire [159:0] swlChallenge,
    input wire swlReq,
    input wire swlDone,
    input wire authBusy,
    input wire engineSleep
);
// ****************
// stuck-line counter
// ****************
integer lowCnt_q;
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
        lowCnt_q <= 0;
    else if (sclIn && sdaIn)
        lowCnt_q <= 0;
    else
        lowCnt_q <= lowCnt_q + 1;
end
// ****************
// assertions
// ****************
default clocking dc @(posedge clock); endclocking
default disable iff (!rst_n);
a_pins_const: assert property (sclOut == 1'b0 && sdaOut == 1'b0 && sclOen_n)
    else $error("clock pin driven or data level wrong");
a_stuck_release: assert property (lowCnt_q >= STUCK_CYCLES + 4 |-> sdaOen_n)
    else $error("data line held past stuck timeout");
a_sleep_cause: assert property ($rose(engineSleep) |-> lowCnt_q >= STUCK_CYCLES)
    else $error("sleep entered without stuck lines");
a_sda_edge: assert property ($changed(sdaOen_n) && lowCnt_q < STUCK_CYCLES |-> !sclIn)
    else $error("data drive changed while clock high");
a_digest_time: assert property ($rose(authBusy) && !extAuthMode |-> authBusy [*8] ##[1:400] !authBusy)
    else $error("digest computation time out of range");
a_req_pulse: assert property (swlReq |=> !swlReq)
    else $error("link request longer than one cycle");
a_req_relay: assert property (swlReq |-> extAuthMode)
    else $error("link request in internal mode");
a_chal_hold: assert property (swlReq |=> $stable(swlChallenge))
    else $error("link challenge changed after request");
a_done_idle: assert property (swlDone && authBusy |=> !authBusy)
    else $error("busy not cleared by link digest");
endmodule // ghia_host_port_chk

bind ghia_host_port ghia_host_port_chk #(.STUCK_CYCLES(STUCK_CYCLES)) u_ghia_host_port_chk (
    .clock(clock),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sclOut(sclOut),
    .sclOen_n(sclOen_n),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOen_n(sdaOen_n),
    .extAuthMode(extAuthMode),
    .swlChallenge(swlChallenge),
    .swlReq(swlReq),
    .swlDone(swlDone),
    .authBusy(authBusy),
    .engineSleep(engineSleep)
);

// ===== tb/ghia_mst.sv
/*
  Two-wire bus master model for the host side of the gauge port.
  Assumes the bench ANDs its drive with the port's drive (pull-up wires).
*/
`timescale 1ns/1ps
module ghia_mst (
    input wire clock,
    input wire sdaIn,
    output reg sclDrv,
    output reg sdaDrv
);
// ****************
// bus primitives
// ****************
initial
begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
end
task w(input integer n);
begin
    repeat (n) @(negedge clock);
end
endtask
task start;
begin
    sdaDrv = 1'b1;
    w(2);
    sclDrv = 1'b1;
    w(4);
    sdaDrv = 1'b0;
    w(4);
    sclDrv = 1'b0;
    w(2);
end
endtask
task stop;
begin
    sdaDrv = 1'b0;
    w(2);
    sclDrv = 1'b1;
    w(4);
    sdaDrv = 1'b1;
    w(4);
end
endtask
task bitx(input b, output r);
begin
    sdaDrv = b;
    w(2);
    sclDrv = 1'b1;
    w(2);
    r = sdaIn;
    w(2);
    sclDrv = 1'b0;
    w(2);
end
endtask
task byteW(input [7:0] d, output ack);
    integer i;
    reg r;
begin
    for (i = 7; i >= 0; i = i - 1)
        bitx(d[i], r);
    bitx(1'b1, ack);
end
endtask
task byteR(output [7:0] d, input nack);
    integer i;
    reg r;
begin
    for (i = 7; i >= 0; i = i - 1)
        bitx(1'b1, d[i]);
    bitx(nack, r);
end
endtask
task hold(input v);
begin
    sclDrv = v;
    sdaDrv = 1'b1;
end
endtask
endmodule // ghia_mst

// ===== tb/tb_top.sv
/*
  Self-checking bench for the gauge host command port.
  Assumes the master model and the bound checker; the link side is modelled here.
*/
`timescale 1ns/1ps
module tb_top;
localparam STUCK = 400;
localparam [159:0] LINK_DIG = {8{20'h5a3c9}};
reg clock, rst_n, clkEn, openState, extAuthMode, swlDone, a;
reg [159:0] swlDigest, chal, dg, d0;
reg [7:0] s, b;
integer errors, numChecks, k;
wire sclOut, sclOen_n, sdaOut, sdaOen_n, swlReq, authBusy, engineSleep, sclDrv, sdaDrv;
wire [159:0] swlChallenge;
wire sclLine = sclDrv & sclOen_n;
wire sdaLine = sdaDrv & sdaOen_n;
ghia_host_port #(.STUCK_CYCLES(STUCK)) u_ghia_host_port (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .sclIn(sclLine), .sclOut(sclOut), .sclOen_n(sclOen_n), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOen_n(sdaOen_n), .openState(openState), .extAuthMode(extAuthMode), .swlChallenge(swlChallenge),
    .swlReq(swlReq), .swlDigest(swlDigest), .swlDone(swlDone), .authBusy(authBusy), .engineSleep(engineSleep));
ghia_mst u_ghia_mst (.clock(clock), .sdaIn(sdaLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
// ****************
// checks and bus tasks
// ****************
task stop_test;
begin
    if (errors == 0 && numChecks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
end
endtask
task chk(input [95:0] nm, input [159:0] e, input [159:0] g);
begin
    numChecks = numChecks + 1;
    if (g !== e)
    begin
        errors = errors + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
    end
end
endtask
task wr(input [7:0] c, input [7:0] d, input e);
begin
    u_ghia_mst.start;
    u_ghia_mst.byteW(8'haa, a);
    chk("addr ack", 0, a);
    u_ghia_mst.byteW(c, a);
    chk("cmd ack", 0, a);
    u_ghia_mst.byteW(d, a);
    chk("data ack", e, a);
    u_ghia_mst.stop;
end
endtask
task rd(input [7:0] c, input integer n, output [159:0] v);
begin
    v = 0;
    u_ghia_mst.start;
    u_ghia_mst.byteW(8'haa, a);
    u_ghia_mst.byteW(c, a);
    chk("rd cmd ack", 0, a);
    u_ghia_mst.start;
    u_ghia_mst.byteW(8'hab, a);
    chk("rd addr ack", 0, a);
    for (k = 0; k < n; k = k + 1)
    begin
        u_ghia_mst.byteR(b, k == n - 1);
        v = {v[151:0], b};
    end
    u_ghia_mst.stop;
end
endtask
task fill(input integer n, input [7:0] seed, input z);
begin
    s = 8'h00;
    for (k = 0; k < n; k = k + 1)
    begin
        b = (z && k >= 12 && k < 28) ? 8'h00 : seed + k[7:0];
        wr(8'h40 + k[7:0], b, 1'b0);
        s = s + b;
    end
end
endtask
task keyTry(input good, input z);
begin
    wr(8'h61, 8'h00, 1'b0);
    wr(8'h3e, 8'h70, 1'b0);
    wr(8'h3f, 8'h00, 1'b0);
    fill(32, 8'ha0, z);
    wr(8'h60, good ? ~s : s, 1'b0);
end
endtask
task query(input good, output [159:0] v);
begin
    if (openState)
        wr(8'h61, 8'h01, 1'b0);
    else
        wr(8'h3f, 8'h00, 1'b0);
    fill(20, 8'h10, 1'b0);
    wr(8'h54, good ? ~s : s, 1'b0);
    chk("busy start", good, authBusy);
    for (k = 0; k < 600 && authBusy === 1'b1; k = k + 1)
        @(negedge clock);
    chk("busy end", 0, authBusy);
    rd(8'h40, 20, v);
    if (!good)
        chk("chal kept", chal, v);
end
endtask
// ****************
// link side and clock
// ****************
always @(negedge clock)
begin
    if (swlReq === 1'b1)
    begin
        chk("link chal", chal, swlChallenge);
        repeat (40) @(negedge clock);
        swlDigest = LINK_DIG;
        swlDone = 1'b1;
        @(negedge clock);
        swlDone = 1'b0;
        swlDigest = ~LINK_DIG;
    end
end
initial
begin
    clock = 1'b0;
    forever #5 clock = ~clock;
end
initial
begin
    #950000;
    errors = errors + 1;
    stop_test;
end
// ****************
// test sequence
// ****************
initial
begin
    clkEn = 1'b1;
    rst_n = 1'b0;
    openState = 1'b1;
    extAuthMode = 1'b0;
    swlDone = 1'b0;
    swlDigest = ~LINK_DIG;
    errors = 0;
    numChecks = 0;
    chal = 0;
    for (k = 0; k < 20; k = k + 1)
        chal = {chal[151:0], 8'h10 + k[7:0]};
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    u_ghia_mst.start;
    u_ghia_mst.byteW(8'hac, a);
    chk("other addr", 1, a);
    u_ghia_mst.stop;
    wr(8'h3f, 8'h5a, 1'b0);
    wr(8'h3e, 8'h70, 1'b0);
    u_ghia_mst.start;
    u_ghia_mst.byteW(8'hab, a);
    u_ghia_mst.byteR(b, 1'b1);
    chk("quick read", 8'h5a, b);
    u_ghia_mst.stop;
    rd(8'h3e, 2, dg);
    chk("incr read", 16'h705a, dg[15:0]);
    wr(8'h10, 8'h55, 1'b1);
    u_ghia_mst.start;
    u_ghia_mst.byteW(8'haa, a);
    u_ghia_mst.byteW(8'h80, a);
    chk("high cmd", 1, a);
    u_ghia_mst.stop;
    u_ghia_mst.start;
    u_ghia_mst.byteW(8'haa, a);
    u_ghia_mst.byteW(8'h3f, a);
    u_ghia_mst.byteW(8'h00, a);
    u_ghia_mst.byteW(8'h11, a);
    chk("extra data", 1, a);
    u_ghia_mst.stop;
    query(1'b1, d0);
    chk("digest new", 1, d0 !== chal);
    openState = 1'b0;
    keyTry(1'b1, 1'b0);
    query(1'b1, dg);
    chk("locked key", d0, dg);
    openState = 1'b1;
    keyTry(1'b0, 1'b0);
    query(1'b0, dg);
    query(1'b1, dg);
    chk("bad sum key", d0, dg);
    keyTry(1'b1, 1'b0);
    query(1'b1, dg);
    chk("new key", 1, dg !== d0);
    keyTry(1'b1, 1'b1);
    extAuthMode = 1'b1;
    query(1'b1, dg);
    chk("link digest", LINK_DIG, dg);
    u_ghia_mst.start;
    b = 8'haa;
    for (k = 0; k < 8; k = k + 1)
        u_ghia_mst.bitx(b[7 - k], a);
    u_ghia_mst.hold(1'b0);
    u_ghia_mst.w(4);
    u_ghia_mst.hold(1'b1);
    repeat (STUCK + 20) @(negedge clock);
    chk("ack released", 1, sdaLine);
    chk("no sleep", 0, engineSleep);
    u_ghia_mst.hold(1'b0);
    repeat (2 * STUCK + 20) @(negedge clock);
    chk("sleep", 1, engineSleep);
    u_ghia_mst.hold(1'b1);
    repeat (10) @(negedge clock);
    chk("wake", 0, engineSleep);
    stop_test;
end
endmodule // tb_top
